// File: deglitch_debounce_pkg.sv
// constants shared by the input conditioning chain
// Notes on behaviour
// [RULE1] With deglitch on, a new level is accepted only after it stood for the deglitch count.
// [RULE2] The deglitch stage delays its output, and shorter pulses never reach that output.
// [RULE3] With debounce on, a first change passes at once, then holds for the debounce count.
// [RULE4] The debounce stage is fed by the deglitched level, not by the raw sampled input.
// [RULE5] If the hold ends with the input still different, the output follows and holds again.
// [RULE6] Each stage is enabled and counted on its own; the controlling party picks each count.
// [RULE7] Durations are sample-tick counts; a zero count passes that stage straight through.
package deglitch_debounce_pkg;
   localparam int count_width = 16;
   localparam logic [15:0] count_zero = 16'h0000;
   localparam logic [15:0] count_one = 16'h0001;
   localparam logic level_reset = 1'b0;
endpackage

// File: input_deglitch_debounce.sv
// deglitch stage followed by debounce stage for one sampled binary level
`timescale 1ns/100ps
`default_nettype none
module input_deglitch_debounce (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // sample tick and raw field level
   input wire logic sample_tick,
   input wire logic raw_in,
   // stage configuration
   input wire logic deglitch_enable,
   input wire logic [deglitch_debounce_pkg::count_width-1:0] deglitch_count,
   input wire logic debounce_enable,
   input wire logic [deglitch_debounce_pkg::count_width-1:0] debounce_count,
   // conditioned outputs
   output logic deglitched,
   output logic debounced
);
   import deglitch_debounce_pkg::*;

   logic raw_meta;
   logic raw_sync;
   logic [15:0] stable_run;
   logic [15:0] hold_left;
   logic next_deglitched;
   logic glitch_on;
   logic bounce_on;

   // two flops: the field level is asynchronous to clock
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         raw_meta <= level_reset;
         raw_sync <= level_reset;
      end else begin
         raw_meta <= raw_in;
         raw_sync <= raw_meta;
      end
   end

   // one decode serves both stages, so their bypass conditions cannot drift apart
   function automatic logic stage_active(input logic enable,
      input logic [count_width-1:0] count);
      return enable && (count != count_zero);
   endfunction

   assign glitch_on = stage_active(deglitch_enable, deglitch_count); // RULE7
   assign bounce_on = stage_active(debounce_enable, debounce_count); // RULE7

   // deglitch: counts ticks the differing level has stood; any return resets the run
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stable_run <= count_zero;
         deglitched <= level_reset;
      end else if (!glitch_on) begin
         stable_run <= count_zero;
         deglitched <= raw_sync; // RULE6
      end else if (sample_tick) begin
         if (raw_sync == deglitched) begin
            stable_run <= count_zero; // RULE2
         end else if (stable_run + count_one >= deglitch_count) begin
            stable_run <= count_zero;
            deglitched <= raw_sync; // RULE1
         end else begin
            stable_run <= stable_run + count_one;
         end
      end
   end

   // the debounce stage reads the deglitched level, never the raw sample
   assign next_deglitched = deglitched; // RULE4

   // debounce: first change passes, then frozen for the hold count
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hold_left <= count_zero;
         debounced <= level_reset;
      end else if (!bounce_on) begin
         hold_left <= count_zero;
         debounced <= next_deglitched; // RULE6
      end else if (sample_tick) begin
         if (hold_left != count_zero) begin
            hold_left <= hold_left - count_one; // RULE3
         end else if (next_deglitched != debounced) begin
            debounced <= next_deglitched; // RULE3
            hold_left <= debounce_count; // RULE5
         end
      end
   end

   // a lone differing sample must not pass the deglitch stage when the count exceeds one
   property p_glitch_blocked;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && deglitch_count > count_one && sample_tick && raw_sync != deglitched
       && stable_run == count_zero && $stable(deglitch_count)) |=> $stable(deglitched);
   endproperty
   a_glitch_blocked: assert property (p_glitch_blocked) // RULE2
      else $error("deglitch passed a short pulse");

   property p_deglitch_changes_only_on_tick;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && !sample_tick && $past(glitch_on)) |=> $stable(deglitched);
   endproperty
   a_deglitch_changes_only_on_tick: assert property (p_deglitch_changes_only_on_tick) // RULE1
      else $error("deglitch moved without a tick");

   property p_deglitch_needs_full_run;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && $past(glitch_on) && $changed(deglitched)) |->
         ($past(stable_run) + count_one >= $past(deglitch_count));
   endproperty
   a_deglitch_needs_full_run: assert property (p_deglitch_needs_full_run) // RULE1
      else $error("deglitch accepted early");

   property p_bypass_deglitch;
      @(posedge clock) disable iff (!rstn)
      !glitch_on |=> deglitched == $past(raw_sync);
   endproperty
   a_bypass_deglitch: assert property (p_bypass_deglitch) // RULE7
      else $error("deglitch bypass not direct");

   property p_bypass_debounce;
      @(posedge clock) disable iff (!rstn)
      !bounce_on |=> debounced == $past(deglitched);
   endproperty
   a_bypass_debounce: assert property (p_bypass_debounce) // RULE4
      else $error("debounce bypass not direct");

   property p_first_change_immediate;
      @(posedge clock) disable iff (!rstn)
      (bounce_on && sample_tick && hold_left == count_zero && deglitched != debounced)
         |=> (debounced == $past(deglitched)) && (hold_left == $past(debounce_count));
   endproperty
   a_first_change_immediate: assert property (p_first_change_immediate) // RULE3
      else $error("debounce did not follow at once");

   property p_held_during_hold;
      @(posedge clock) disable iff (!rstn)
      (bounce_on && hold_left != count_zero) |=> $stable(debounced);
   endproperty
   a_held_during_hold: assert property (p_held_during_hold) // RULE3
      else $error("debounce moved during hold");

   property p_rearm_after_hold;
      @(posedge clock) disable iff (!rstn)
      (bounce_on && $past(bounce_on) && $changed(debounced)) |-> hold_left == $past(debounce_count);
   endproperty
   a_rearm_after_hold: assert property (p_rearm_after_hold) // RULE5
      else $error("debounce hold not restarted");

   // deglitch run counter: restarts on a matching sample, advances only on a differing one
   property p_deglitch_run_restart;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && sample_tick && raw_sync == deglitched)
         |=> (stable_run == count_zero) && $stable(deglitched);
   endproperty
   a_deglitch_run_restart: assert property (p_deglitch_run_restart) // RULE2
      else $error("deglitch run not restarted");

   property p_deglitch_accept;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && sample_tick && raw_sync != deglitched
       && stable_run + count_one >= deglitch_count)
         |=> (deglitched == $past(raw_sync)) && (stable_run == count_zero);
   endproperty
   a_deglitch_accept: assert property (p_deglitch_accept) // RULE1
      else $error("deglitch did not accept a full run");

   property p_deglitch_count_up;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && sample_tick && raw_sync != deglitched
       && stable_run + count_one < deglitch_count)
         |=> (stable_run == $past(stable_run) + count_one) && $stable(deglitched);
   endproperty
   a_deglitch_count_up: assert property (p_deglitch_count_up) // RULE1
      else $error("deglitch run did not advance");

   property p_deglitch_waits_tick;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && !sample_tick) |=> $stable(stable_run) && $stable(deglitched);
   endproperty
   a_deglitch_waits_tick: assert property (p_deglitch_waits_tick) // RULE1
      else $error("deglitch counted without a tick");

   property p_deglitch_moves_on_tick;
      @(posedge clock) disable iff (!rstn)
      (glitch_on && $past(glitch_on) && $changed(deglitched)) |-> $past(sample_tick);
   endproperty
   a_deglitch_moves_on_tick: assert property (p_deglitch_moves_on_tick) // RULE2
      else $error("deglitch changed off a tick");

   property p_deglitch_fed_by_sync;
      @(posedge clock) disable iff (!rstn)
      $changed(deglitched) |-> (deglitched == $past(raw_sync));
   endproperty
   a_deglitch_fed_by_sync: assert property (p_deglitch_fed_by_sync) // RULE1
      else $error("deglitch took a level it never saw");

   // a bypassed stage must not keep stale counts for when it is switched back on
   property p_deglitch_bypass_clears;
      @(posedge clock) disable iff (!rstn)
      !glitch_on |=> (stable_run == count_zero);
   endproperty
   a_deglitch_bypass_clears: assert property (p_deglitch_bypass_clears) // RULE7
      else $error("deglitch run kept while bypassed");

   property p_debounce_bypass_clears;
      @(posedge clock) disable iff (!rstn)
      !bounce_on |=> (hold_left == count_zero);
   endproperty
   a_debounce_bypass_clears: assert property (p_debounce_bypass_clears) // RULE7
      else $error("debounce hold kept while bypassed");

   // debounce hold counter
   property p_hold_counts_down;
      @(posedge clock) disable iff (!rstn)
      (bounce_on && sample_tick && hold_left != count_zero)
         |=> (hold_left == $past(hold_left) - count_one);
   endproperty
   a_hold_counts_down: assert property (p_hold_counts_down) // RULE3
      else $error("debounce hold did not count down");

   property p_hold_waits_tick;
      @(posedge clock) disable iff (!rstn)
      (bounce_on && !sample_tick) |=> $stable(hold_left) && $stable(debounced);
   endproperty
   a_hold_waits_tick: assert property (p_hold_waits_tick) // RULE3
      else $error("debounce moved without a tick");

   property p_debounce_idle;
      @(posedge clock) disable iff (!rstn)
      (bounce_on && sample_tick && hold_left == count_zero && deglitched == debounced)
         |=> $stable(debounced) && (hold_left == count_zero);
   endproperty
   a_debounce_idle: assert property (p_debounce_idle) // RULE3
      else $error("debounce moved with no input change");

   property p_debounce_moves_on_tick;
      @(posedge clock) disable iff (!rstn)
      (bounce_on && $past(bounce_on) && $changed(debounced)) |-> $past(sample_tick);
   endproperty
   a_debounce_moves_on_tick: assert property (p_debounce_moves_on_tick) // RULE3
      else $error("debounce changed off a tick");

   property p_debounce_fed_by_deglitch;
      @(posedge clock) disable iff (!rstn)
      $changed(debounced) |-> (debounced == $past(deglitched));
   endproperty
   a_debounce_fed_by_deglitch: assert property (p_debounce_fed_by_deglitch) // RULE4
      else $error("debounce took a level not from deglitch");
endmodule
`default_nettype wire

// File: field_contact.sv
// field contact model that bounces after each commanded level change
`timescale 1ns/100ps
`default_nettype none
module field_contact (
   // clock and command
   input wire logic clock,
   input wire logic level,
   input wire logic [3:0] bounces,
   // contact level seen by the block
   output logic raw
);
   logic [3:0] left = 4'h0;
   logic last = 1'b0;
   initial raw = 1'b0;
   // real relays chatter after a change, so the level toggles before it settles
   always @(posedge clock) begin
      if (level !== last) begin
         left <= bounces;
         last <= level;
         raw <= level;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
         raw <= ~raw;
      end else begin
         raw <= last;
      end
   end
endmodule
`default_nettype wire

// File: input_deglitch_debounce_tb.sv
// self-checking bench for the deglitch and debounce chain
`timescale 1ns/100ps
`default_nettype none
module input_deglitch_debounce_tb;
   import deglitch_debounce_pkg::*;
   logic clock = 1'b0, rstn = 1'b0, sample_tick = 1'b1, level = 1'b0, dg_en = 1'b0;
   logic db_en = 1'b0, tick_slow = 1'b0, raw_in, deglitched, debounced;
   logic [15:0] dg_cnt = 16'h0000, db_cnt = 16'h0000;
   logic [3:0] bounces = 4'h0;
   logic exp_q[$];
   int err_total = 0, num_checks = 0, seed = 32'h619a_1f64;
   always #25 clock = ~clock;
   // slow mode gives a one-cycle tick every other clock, as a divider would
   always @(posedge clock) #5 sample_tick = !tick_slow || !sample_tick;
   field_contact contact (.clock(clock), .level(level), .bounces(bounces), .raw(raw_in));
   input_deglitch_debounce dut (.clock(clock), .rstn(rstn), .sample_tick(sample_tick),
      .raw_in(raw_in), .deglitch_enable(dg_en), .deglitch_count(dg_cnt),
      .debounce_enable(db_en), .debounce_count(db_cnt), .deglitched(deglitched),
      .debounced(debounced));
   task automatic check(string what, logic e, logic s);
      num_checks++;
      if (e !== s) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", what, e, s);
      end
   endtask
   // a change with no note left is a spurious change, hence the inverted stand-in
   always @(debounced) if (rstn === 1'b1)
      check("debounced", exp_q.size() > 0 ? exp_q.pop_front() : ~debounced, debounced);
   task automatic cfg(logic ge, logic [15:0] gc, logic be, logic [15:0] bc);
      dg_en = ge;
      dg_cnt = gc;
      db_en = be;
      db_cnt = bc;
   endtask
   task automatic step(logic lvl, logic [3:0] b, int cycles, bit note);
      if (note) exp_q.push_back(lvl);
      bounces = b;
      level = lvl;
      repeat (cycles) @(posedge clock);
      #5;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #(1000 * 50);
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge clock);
      #5 rstn = 1'b1;
      cfg(1'b1, 16'h0004, 1'b0, 16'h0000);
      step(1'b1, 4'h0, 1 + {$random(seed)} % 3, 1'b0);
      step(1'b0, 4'h0, 12, 1'b0);
      check("deglitched", 1'b0, deglitched);
      step(1'b1, 4'h0, 12, 1'b1);
      step(1'b0, 4'h0, 12, 1'b1);
      $display("deglitch test done");
      cfg(1'b0, 16'h0000, 1'b1, 16'h0006);
      step(1'b1, 4'h5, 20, 1'b1);
      step(1'b0, 4'h5, 20, 1'b1);
      $display("debounce test done");
      // a short high level is still held for the whole count, then followed down
      step(1'b1, 4'h0, 2, 1'b1);
      step(1'b0, 4'h0, 4, 1'b1);
      check("debounced held", 1'b1, debounced);
      check("deglitched", 1'b0, deglitched);
      step(1'b0, 4'h0, 14, 1'b0);
      check("debounced", 1'b0, debounced);
      $display("hold expiry test done");
      // bounces outlast the hold, so only a deglitched feed yields one change
      cfg(1'b1, 16'h0003, 1'b1, 16'h0005);
      step(1'b1, 4'h9, 24, 1'b1);
      step(1'b0, 4'h9, 24, 1'b1);
      $display("chain test done");
      tick_slow = 1'b1;
      cfg(1'b1, 16'h0003, 1'b1, 16'h0002);
      step(1'b1, 4'h0, 1 + {$random(seed)} % 4, 1'b0);
      step(1'b0, 4'h0, 12, 1'b0);
      check("deglitched", 1'b0, deglitched);
      check("debounced", 1'b0, debounced);
      step(1'b1, 4'h0, 30, 1'b1);
      check("deglitched", 1'b1, deglitched);
      step(1'b0, 4'h0, 30, 1'b1);
      check("deglitched", 1'b0, deglitched);
      tick_slow = 1'b0;
      $display("slow tick test done");
      cfg(1'b1, 16'h0000, 1'b1, 16'h0000);
      step(1'b1, 4'h0, 1, 1'b1);
      step(1'b0, 4'h0, 8, 1'b1);
      check("notes left", 1'b1, exp_q.size() == 0);
      $display("bypass test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
